// ==== sath_cfg.svh ====
`ifndef SATH_CFG_SVH
`define SATH_CFG_SVH

`define SATH_SYNC_W          5
`define SATH_PIN_SCLK        0
`define SATH_PIN_CS_N        1
`define SATH_PIN_DIN         2
`define SATH_PIN_COMP        3
`define SATH_PIN_NEG         4
// select pin resets to its idle high level, the rest low
`define SATH_SYNC_IDLE       5'h02

`define SATH_CNT_TRACK       4'h4
`define SATH_CNT_CLKSRC      4'h5
`define SATH_CNT_HOLD        4'h6
`define SATH_CNT_FULL        4'h8
`define SATH_CNT_START       4'h1
`define SATH_RESULT_BITS     4'h8

`define SATH_SEL_HI          2
`define SATH_SEL_LO          0
`define SATH_SEL_VDD_MON     3'h0
`define SATH_SEL_CH0_CH1     3'h1
`define SATH_BIPOLAR_BIT     2
`define SATH_CH_PICK_BIT     0
`define SATH_COM_BIT         1

`define SATH_MSB_ONLY        8'h80
`define SATH_ZERO_CODE       8'h00

`define SATH_CLK_PERIOD_NS   20
`define SATH_CONV_DUR_NS     35000
`define SATH_SAR_STEPS       8
`define SATH_STEP_CYCLES \
    (`SATH_CONV_DUR_NS / `SATH_CLK_PERIOD_NS / `SATH_SAR_STEPS)
`define SATH_DIV_W           8

`endif

// ==== sath_pkg.sv ====
package sath_pkg;
    typedef enum logic [1:0] {
        SATH_HUNT = 2'b00,
        SATH_CTRL = 2'b01,
        SATH_BUSY = 2'b10
    } sath_state_t;

    typedef enum logic [1:0] {
        SATH_SI_ZERO    = 2'b00,
        SATH_SI_ONE     = 2'b01,
        SATH_SI_VDD_MON = 2'b10
    } sath_sampled_t;

    typedef enum logic [1:0] {
        SATH_RI_COM = 2'b00,
        SATH_RI_GND = 2'b01,
        SATH_RI_ONE = 2'b10
    } sath_reference_t;
endpackage

// ==== sath_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sath_cfg.svh"
module sath_sync
    import sath_pkg::*;
(
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    input  wire logic [`SATH_SYNC_W-1:0] async_in,
    output logic      [`SATH_SYNC_W-1:0] sync_out
);
    logic [`SATH_SYNC_W-1:0] meta_reg;
    logic [`SATH_SYNC_W-1:0] meta_next;
    logic [`SATH_SYNC_W-1:0] sync_reg;
    logic [`SATH_SYNC_W-1:0] sync_next;
    // a zero here would read as selected for two cycles after reset
    localparam logic [`SATH_SYNC_W-1:0] idle_lvl = `SATH_SYNC_IDLE;

    ////////////////////////////////////////////////////////////////////
    // two flops per pin; first stage is read only by the second
    genvar i;
    generate
        for (i = 0; i < `SATH_SYNC_W; i = i + 1) begin : g_bit
            always_comb begin
                meta_next[i] = ce ? async_in[i] : meta_reg[i];
                sync_next[i] = ce ? meta_reg[i] : sync_reg[i];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    meta_reg[i] <= idle_lvl[i];
                    sync_reg[i] <= idle_lvl[i];
                end else begin
                    meta_reg[i] <= meta_next[i];
                    sync_reg[i] <= sync_next[i];
                end
            end
        end
    endgenerate

    assign sync_out = sync_reg;
endmodule // sath_sync
`default_nettype wire

// ==== sath_sar.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sath_cfg.svh"
module sath_sar
    import sath_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    input  wire logic       start,
    input  wire logic       step,
    input  wire logic       comp_hi,
    output logic      [7:0] trial_code,
    output logic      [7:0] result,
    output logic            done
);
    logic [7:0] trial_reg;
    logic [7:0] trial_next;
    logic [7:0] mask_reg;
    logic [7:0] mask_next;
    logic [7:0] result_reg;
    logic [7:0] result_next;
    logic       done_reg;
    logic       done_next;
    logic [7:0] kept;

    ////////////////////////////////////////////////////////////////////
    // one bit decided per step, msb first; mask empty means idle
    always_comb begin
        trial_next  = trial_reg;
        mask_next   = mask_reg;
        result_next = result_reg;
        done_next   = 1'b0;
        kept        = comp_hi ? trial_reg : (trial_reg & ~mask_reg);
        if (start) begin
            trial_next = `SATH_MSB_ONLY;
            mask_next  = `SATH_MSB_ONLY;
        end else if (step && (mask_reg != `SATH_ZERO_CODE)) begin
            mask_next  = mask_reg >> 1;
            trial_next = kept | (mask_reg >> 1);
            if (mask_reg[0]) begin
                result_next = kept; // full 8-bit word
                done_next   = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trial_reg  <= `SATH_ZERO_CODE;
            mask_reg   <= `SATH_ZERO_CODE;
            result_reg <= `SATH_ZERO_CODE;
            done_reg   <= 1'b0;
        end else if (ce) begin
            trial_reg  <= trial_next;
            mask_reg   <= mask_next;
            result_reg <= result_next;
            done_reg   <= done_next;
        end
    end

    assign trial_code = trial_reg;
    assign result     = result_reg;
    assign done       = done_reg;
endmodule // sath_sar
`default_nettype wire

// ==== sath_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "sath_cfg.svh"
module sath_ctrl
    import sath_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             ce,
    input  wire logic             cs_n,
    input  wire logic             sclk,
    input  wire logic             din,
    input  wire logic             comp_hi,
    input  wire logic             neg_diff,
    output logic                  dout,
    output logic                  dout_oe,
    output logic                  tracking,
    output logic                  conv_busy,
    output sath_sampled_t         sampled_input,
    output sath_reference_t       reference_input,
    output logic                  bipolar,
    output logic                  conversion_clock_source_bit,
    output logic                  reference_source_bit,
    output logic      [1:0]       power_bits,
    output logic      [7:0]       dac_code,
    output logic      [7:0]       result,
    output logic                  result_valid
);
    ////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [`SATH_SYNC_W-1:0] pins_raw;
    logic [`SATH_SYNC_W-1:0] pins_s;
    logic                    sclk_s;
    logic                    cs_low;
    logic                    din_s;
    logic                    comp_s;
    logic                    neg_s;

    assign pins_raw = {neg_diff, comp_hi, din, cs_n, sclk};
    assign sclk_s   = pins_s[`SATH_PIN_SCLK];
    assign cs_low   = ~pins_s[`SATH_PIN_CS_N];
    assign din_s    = pins_s[`SATH_PIN_DIN];
    assign comp_s   = pins_s[`SATH_PIN_COMP];
    assign neg_s    = pins_s[`SATH_PIN_NEG];

    sath_sync u_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    ////////////////////////////////////////////////////////////////////
    // state
    sath_state_t     state_reg,      state_next;
    logic [3:0]      bit_cnt_reg,    bit_cnt_next;
    logic [7:0]      shift_reg,      shift_next;
    logic [2:0]      sel_reg,        sel_next;
    logic            clk_src_reg,    clk_src_next;
    logic            ref_src_reg,    ref_src_next;
    logic [1:0]      power_reg,      power_next;
    logic            track_pend_reg, track_pend_next;
    logic            hold_pend_reg,  hold_pend_next;
    logic            tracking_reg,   tracking_next;
    logic            busy_reg,       busy_next;
    logic            neg_reg,        neg_next;
    logic [`SATH_DIV_W-1:0] div_reg, div_next;
    logic [7:0]      out_shift_reg,  out_shift_next;
    logic [3:0]      out_cnt_reg,    out_cnt_next;
    logic            dout_reg,       dout_next;
    logic            dout_oe_reg,    dout_oe_next;
    logic [7:0]      result_reg,     result_next;
    logic            valid_reg,      valid_next;
    logic            sclk_prev_reg;
    sath_sampled_t   si_reg,         si_next;
    sath_reference_t ri_reg,         ri_next;
    logic            bip_reg,        bip_next;
    logic [7:0]      dac_reg;

    logic            sclk_rise;
    logic            sclk_fall;
    logic            conv_start;
    logic            div_tick;
    logic            sar_step;
    logic [7:0]      sar_trial;
    logic [7:0]      sar_result;
    logic            sar_done;
    logic [7:0]      coded;

    // edges come from the synchronised copy, never the raw pin
    assign sclk_rise = sclk_s & ~sclk_prev_reg;
    assign sclk_fall = ~sclk_s & sclk_prev_reg;

    ////////////////////////////////////////////////////////////////////
    // conversion pacing: serial clock falls or the internal divider
    assign div_tick   = busy_reg &&
        (div_reg == `SATH_DIV_W'(`SATH_STEP_CYCLES - 1));
    assign sar_step   = busy_reg &&
        (clk_src_reg ? sclk_fall : div_tick);
    assign conv_start = hold_pend_reg && sclk_fall && cs_low;

    sath_sar u_sar (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .start      (conv_start),
        .step       (sar_step),
        .comp_hi    (comp_s),
        .trial_code (sar_trial),
        .result     (sar_result),
        .done       (sar_done)
    );

    // coding of the finished word
    always_comb begin
        if (!bip_reg && neg_reg)
            coded = `SATH_ZERO_CODE;
        else if (bip_reg)
            coded = sar_result ^ `SATH_MSB_ONLY;
        else
            coded = sar_result;
    end

    ////////////////////////////////////////////////////////////////////
    // configuration decode from the select field
    always_comb begin
        bip_next = (sel_reg[`SATH_BIPOLAR_BIT] == 1'b0) &&
                   (sel_reg != `SATH_SEL_VDD_MON);
        if (sel_reg == `SATH_SEL_VDD_MON)
            si_next = SATH_SI_VDD_MON;
        else if (sel_reg[`SATH_CH_PICK_BIT])
            si_next = SATH_SI_ZERO;
        else
            si_next = SATH_SI_ONE;
        if (sel_reg == `SATH_SEL_CH0_CH1)
            ri_next = SATH_RI_ONE;
        else if (sel_reg[`SATH_COM_BIT])
            ri_next = SATH_RI_COM;
        else
            ri_next = SATH_RI_GND;
    end

    ////////////////////////////////////////////////////////////////////
    // control byte reception and track/hold sequencing
    always_comb begin
        state_next      = state_reg;
        bit_cnt_next    = bit_cnt_reg;
        shift_next      = shift_reg;
        sel_next        = sel_reg;
        clk_src_next    = clk_src_reg;
        ref_src_next    = ref_src_reg;
        power_next      = power_reg;
        track_pend_next = track_pend_reg;
        hold_pend_next  = hold_pend_reg;
        tracking_next   = tracking_reg;
        busy_next       = busy_reg;
        neg_next        = neg_reg;
        result_next     = result_reg;
        valid_next      = 1'b0;
        div_next        = div_reg;
        if (!cs_low) begin
            // fresh start-bit hunt on every select low period
            state_next      = SATH_HUNT;
            bit_cnt_next    = 4'h0;
            track_pend_next = 1'b0;
            hold_pend_next  = 1'b0;
        end else begin
            case (state_reg)
                SATH_HUNT: begin
                    // zeros before the start bit do nothing
                    if (sclk_rise && din_s) begin
                        state_next   = SATH_CTRL;
                        shift_next   = {7'h00, 1'b1};
                        bit_cnt_next = `SATH_CNT_START;
                    end
                end
                SATH_CTRL: begin
                    if (sclk_rise) begin
                        shift_next   = {shift_reg[6:0], din_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                        if (bit_cnt_next == `SATH_CNT_TRACK) begin
                            sel_next        = shift_next[2:0];
                            track_pend_next = 1'b1;
                        end
                        if (bit_cnt_next == `SATH_CNT_CLKSRC)
                            clk_src_next = shift_next[0];
                        if (bit_cnt_next == `SATH_CNT_HOLD) begin
                            ref_src_next   = shift_next[0];
                            hold_pend_next = 1'b1;
                        end
                        if (bit_cnt_next == `SATH_CNT_FULL) begin
                            power_next = shift_next[1:0];
                            state_next = SATH_BUSY;
                        end
                    end
                end
                SATH_BUSY: begin
                    // byte complete; wait for select to rise
                    state_next = SATH_BUSY;
                end
                default: begin
                    state_next = SATH_HUNT;
                end
            endcase
            if (track_pend_reg && sclk_fall) begin
                tracking_next   = 1'b1;
                track_pend_next = 1'b0;
            end
            if (conv_start) begin
                tracking_next  = 1'b0;
                hold_pend_next = 1'b0;
                busy_next      = 1'b1;
                neg_next       = neg_s;
                div_next       = `SATH_DIV_W'(0);
            end
        end
        if (busy_reg && !conv_start)
            div_next = div_tick ? `SATH_DIV_W'(0) : div_reg + 1'b1;
        if (sar_done) begin
            tracking_next = 1'b1;
            busy_next     = 1'b0;
            result_next   = coded;
            valid_next    = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // result shifter; while selected, output only changes on serial clock falls
    always_comb begin
        out_shift_next = out_shift_reg;
        out_cnt_next   = out_cnt_reg;
        dout_next      = dout_reg;
        dout_oe_next   = cs_low;
        if (!cs_low) begin
            out_cnt_next = 4'h0;
            dout_next    = 1'b0;
        end else if (sar_done) begin
            out_shift_next = coded;
            out_cnt_next   = `SATH_RESULT_BITS;
        end else if (sclk_fall) begin
            if (out_cnt_reg != 4'h0) begin
                dout_next      = out_shift_reg[7];
                out_shift_next = {out_shift_reg[6:0], 1'b0};
                out_cnt_next   = out_cnt_reg - 4'h1;
            end else begin
                dout_next = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers; clock enable freezes everything
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg      <= SATH_HUNT;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= 8'h00;
            sel_reg        <= 3'h7;
            clk_src_reg    <= 1'b0;
            ref_src_reg    <= 1'b0;
            power_reg      <= 2'h0;
            track_pend_reg <= 1'b0;
            hold_pend_reg  <= 1'b0;
            tracking_reg   <= 1'b1;
            busy_reg       <= 1'b0;
            neg_reg        <= 1'b0;
            div_reg        <= `SATH_DIV_W'(0);
            out_shift_reg  <= 8'h00;
            out_cnt_reg    <= 4'h0;
            dout_reg       <= 1'b0;
            dout_oe_reg    <= 1'b0;
            result_reg     <= 8'h00;
            valid_reg      <= 1'b0;
            sclk_prev_reg  <= 1'b0;
            si_reg         <= SATH_SI_ZERO;
            ri_reg         <= SATH_RI_COM;
            bip_reg        <= 1'b0;
            dac_reg        <= 8'h00;
        end else if (ce) begin
            state_reg      <= state_next;
            bit_cnt_reg    <= bit_cnt_next;
            shift_reg      <= shift_next;
            sel_reg        <= sel_next;
            clk_src_reg    <= clk_src_next;
            ref_src_reg    <= ref_src_next;
            power_reg      <= power_next;
            track_pend_reg <= track_pend_next;
            hold_pend_reg  <= hold_pend_next;
            tracking_reg   <= tracking_next;
            busy_reg       <= busy_next;
            neg_reg        <= neg_next;
            div_reg        <= div_next;
            out_shift_reg  <= out_shift_next;
            out_cnt_reg    <= out_cnt_next;
            dout_reg       <= dout_next;
            dout_oe_reg    <= dout_oe_next;
            result_reg     <= result_next;
            valid_reg      <= valid_next;
            sclk_prev_reg  <= sclk_s;
            si_reg         <= si_next;
            ri_reg         <= ri_next;
            bip_reg        <= bip_next;
            dac_reg        <= sar_trial;
        end
    end

    assign dout                        = dout_reg;
    assign dout_oe                     = dout_oe_reg;
    assign tracking                    = tracking_reg;
    assign conv_busy                   = busy_reg;
    assign sampled_input               = si_reg;
    assign reference_input             = ri_reg;
    assign bipolar                     = bip_reg;
    assign conversion_clock_source_bit = clk_src_reg;
    assign reference_source_bit        = ref_src_reg;
    assign power_bits                  = power_reg;
    assign dac_code                    = dac_reg;
    assign result                      = result_reg;
    assign result_valid                = valid_reg;
endmodule // sath_ctrl
`default_nettype wire

// ==== sath_ctrl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
module sath_ctrl_monitor
    import sath_pkg::*;
(
    input wire logic            clk,
    input wire logic            rst_n,
    input wire logic            ce,
    input wire logic            cs_n,
    input wire logic            sclk,
    input wire logic            dout,
    input wire logic            dout_oe,
    input wire logic            tracking,
    input wire logic            conv_busy,
    input wire sath_sampled_t   sampled_input,
    input wire sath_reference_t reference_input,
    input wire logic            bipolar,
    input wire logic [7:0]      result,
    input wire logic            result_valid
);
    logic       sclk_reg, sclk_next;
    logic [3:0] age_reg, age_next;

    // clk edges since the pin clock fell; saturates so idle never wraps
    always_comb begin
        sclk_next = sclk;
        age_next  = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
        if (sclk_reg && !sclk)
            age_next = 4'h0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_reg <= 1'b0;
            age_reg  <= 4'hf;
        end else begin
            sclk_reg <= sclk_next;
            age_reg  <= age_next;
        end
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    // a frozen block keeps no timing promises
    default disable iff (!rst_n || !ce);

    a_oe_off_idle:
        assert property (cs_n [*5] |-> !dout_oe) else $error("oe while idle");
    a_oe_on_select:
        assert property (!cs_n [*5] |-> dout_oe) else $error("oe missing");
    // a change launched by the rise would land just past this window
    a_dout_on_fall:
        assert property (dout_oe && $changed(dout) |-> age_reg inside {[1:5]})
        else $error("dout moved off a fall");
    a_hold_on_fall:
        assert property ($fell(tracking) |-> age_reg inside {[1:5]})
        else $error("hold off a fall");
    a_hold_conv_start:
        assert property ($fell(tracking) |-> ##[0:2] conv_busy)
        else $error("hold without conversion");
    a_busy_in_hold:
        assert property (conv_busy |-> !tracking) else $error("track in conv");
    a_track_after_done:
        assert property ($fell(conv_busy) |-> ##[0:1] tracking)
        else $error("no track after done");
    a_valid_one_cycle:
        assert property (result_valid |=> !result_valid)
        else $error("valid too long");
    a_result_on_valid:
        assert property ($changed(result) |-> result_valid)
        else $error("result moved alone");
    a_cfg_frozen:
        assert property (cs_n [*6] |->
            $stable({sampled_input, reference_input, bipolar}))
        else $error("config moved while deselected");
endmodule // sath_ctrl_monitor

bind sath_ctrl sath_ctrl_monitor u_sath_ctrl_monitor (
    .clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n), .sclk(sclk), .dout(dout),
    .dout_oe(dout_oe), .tracking(tracking), .conv_busy(conv_busy),
    .sampled_input(sampled_input), .reference_input(reference_input),
    .bipolar(bipolar), .result(result), .result_valid(result_valid));
`default_nettype wire

// ==== sath_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module sath_host (
    output logic     cs_n,
    output logic     sclk,
    output logic     din,
    input wire logic dout_pin
);
    logic [31:0] rx;

    // idle: deselected, clock parked low, data at the start-bit level
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        din  = 1'b1;
        rx   = 32'h0;
    end

    // data set after the fall, read back mid high phase
    task automatic pulse(input logic b);
        din = b;
        #80; // half period; the high phase is set by the two 40 ns waits below
        sclk = 1'b1;
        #40;
        rx = {rx[30:0], dout_pin};
        #40;
        sclk = 1'b0;
    endtask

    // zeros, control byte msb first, then ones that must be ignored
    task automatic frame(input logic [7:0] ctl, input int lead,
                         input int n1, input int gap, input int n2);
        cs_n = 1'b0;
        #120;
        for (int i = 0; i < lead + n1 + n2; i++) begin
            if (i == lead + n1)
                #(gap);
            pulse(i < lead ? 1'b0 :
                  (i < lead + 8 ? ctl[7 + lead - i] : 1'b1));
        end
        #80;
        cs_n = 1'b1;
    endtask
endmodule // sath_host
`default_nettype wire

// ==== sath_ctrl_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module sath_ctrl_tb
    import sath_pkg::*;
();
    logic            clk, rst_n, ce, neg_diff, comp_hi;
    logic            cs_n, sclk, din, dout, dout_oe, tracking, conv_busy;
    logic            bipolar, clk_src, ref_src, result_valid;
    wire             dout_pin;
    sath_sampled_t   sampled;
    sath_reference_t refsel;
    logic [1:0]      power_bits;
    logic [7:0]      dac_code, result, ana, exp_code;
    logic [4:0]      cfg_exp [8];
    int              errors = 0;
    int              tests_run = 0;
    int              cycles = 0;

    // comparator stands in for the analog front end
    assign #1 comp_hi = (ana >= dac_code);
    // released pin shows the inverse so a late enable cannot pass
    assign dout_pin = dout_oe ? dout : ~dout;

    sath_ctrl u_sath_ctrl (.clk(clk), .rst_n(rst_n), .ce(ce), .cs_n(cs_n),
        .sclk(sclk), .din(din), .comp_hi(comp_hi), .neg_diff(neg_diff),
        .dout(dout), .dout_oe(dout_oe), .tracking(tracking),
        .conv_busy(conv_busy), .sampled_input(sampled),
        .reference_input(refsel), .bipolar(bipolar),
        .conversion_clock_source_bit(clk_src),
        .reference_source_bit(ref_src), .power_bits(power_bits),
        .dac_code(dac_code), .result(result), .result_valid(result_valid));
    sath_host u_sath_host (.cs_n(cs_n), .sclk(sclk), .din(din),
        .dout_pin(dout_pin));

    ////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // a hang costs one mismatch and still reaches the verdict
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s %h not %h", $time, what,
                     seen, exp);
        end
    endtask

    task automatic give_verdict;
        if (errors == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    ////////////////////////////////////////
    // {sampled, reference, bipolar} for select codes 0..7
    initial begin
        cfg_exp = '{5'h12, 5'h05, 5'h09, 5'h01, 5'h0a, 5'h02, 5'h08, 5'h00};
        rst_n = 1'b0;
        ce = 1'b1;
        neg_diff = 1'b0;
        ana = 8'h00;
        repeat (12) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check(8'(dout_oe), 8'h00, "oe");
        check(8'({sampled, refsel}), 8'h00, "cfg reset");
        // a start bit and zeros while deselected must not reach the config
        for (int i = 0; i < 6; i++)
            u_sath_host.pulse(i < 1);
        check(8'(sampled), 8'(SATH_SI_ZERO), "si idle");
        // enable low: a select low period must not be seen at all
        ce = 1'b0;
        u_sath_host.cs_n = 1'b0;
        repeat (8) @(posedge clk);
        #1;
        check(8'(dout_oe), 8'h00, "ce freeze");
        u_sath_host.cs_n = 1'b1;
        @(posedge clk);
        #1 ce = 1'b1;
        // abort mid byte; the next frame has to hunt from scratch
        u_sath_host.frame(8'hc0, 1, 3, 0, 0);
        for (int s = 0; s < 8; s++) begin
            @(posedge clk);
            #1;
            ana = 8'h96 + 8'(s) * 8'h11;
            neg_diff = (s == 7 || s == 2);
            u_sath_host.frame({1'b1, 3'(s), 4'hf}, s % 3, 24, 0, 0);
            exp_code = cfg_exp[s][0] ? ana ^ 8'h80 : (neg_diff ? 8'h00 : ana);
            repeat (6) @(posedge clk);
            #1;
            check(8'({sampled, refsel, bipolar}), 8'(cfg_exp[s]), "cfg");
            check(u_sath_host.rx[8:1], exp_code, "shifted");
            check(8'(u_sath_host.rx[0]), 8'h00, "tail");
            check(result, exp_code, "result");
            check(8'({clk_src, ref_src, power_bits}), 8'h0f, "src");
            check(8'(dout_oe), 8'h00, "oe");
            if (s == 7)
                check(result, 8'h00, "negative");
        end
        // internal clock: host parks sclk after the control byte, longer than the conversion
        @(posedge clk);
        #1;
        ana = 8'hff;
        neg_diff = 1'b0;
        u_sath_host.frame(8'hf3, 0, 8, 36000, 10);
        repeat (6) @(posedge clk);
        #1;
        check(u_sath_host.rx[8:1], 8'hff, "internal");
        check(8'({clk_src, ref_src, power_bits}), 8'h03, "src");
        give_verdict();
    end
endmodule // sath_ctrl_tb
`default_nettype wire
